//--- verilog/cmpl_map.svh
// register offsets, field positions, reset values and timing counts
`ifndef CMPL_MAP_SVH
`define CMPL_MAP_SVH
`define CMPL_OFS_CTRL_A0 5'h00
`define CMPL_OFS_CTRL_B0 5'h04
`define CMPL_CHAN_STRIDE 5'h08
`define CMPL_OFS_CTRL_A1 5'h08
`define CMPL_OFS_SHARED 5'h10
`define CMPL_OFS_IRQ_FLAG 5'h14
`define CMPL_OFS_IRQ_EN 5'h18
`define CMPL_OFS_IRQ_CTRL 5'h1C
`define CMPL_A_ENABLE 7
`define CMPL_A_OUTPUT 6
`define CMPL_A_INVERT 4
`define CMPL_A_SPEED 2
`define CMPL_A_HYST 1
`define CMPL_A_SYNC 0
`define CMPL_A_WMASK 8'h97
`define CMPL_A_RESET 8'h04
`define CMPL_B_RISE 7
`define CMPL_B_FALL 6
`define CMPL_B_PCH_LSB 3
`define CMPL_B_NCH_LSB 0
`define CMPL_B_RESET 8'h00
`define CMPL_C_GLOBAL 7
`define CMPL_C_PERIPH 6
`define CMPL_INSTR_DIV 4
`endif

//--- verilog/cmpl_pkg.sv
// types shared by the comparator output logic
package cmpl_pkg;
  typedef logic [7:0] cmpl_byte_t;
  typedef enum logic {CMPL_BUS_IDLE, CMPL_BUS_ANSWER} cmpl_bus_t;
endpackage

//--- verilog/cmpl_chan_if.sv
// control and result signals between the top and one comparator channel
`timescale 1ns/10ps
interface cmpl_chan_if;
  logic enable;
  logic invert;
  logic sync_sel;
  logic instr_tick;
  logic timer_fall;
  logic out_bit;
  logic rise;
  logic fall;
  logic ext_out;
  modport host (output enable, invert, sync_sel, instr_tick, timer_fall,
    input out_bit, rise, fall, ext_out);
  modport channel (input enable, invert, sync_sel, instr_tick, timer_fall,
    output out_bit, rise, fall, ext_out);
endinterface // cmpl_chan_if

//--- verilog/cmpl_channel.sv
// one comparator channel: input synchroniser, output latch, edge detectors
`timescale 1ns/10ps
module cmpl_channel
  import cmpl_pkg::*;
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // raw analog result, asynchronous
  input wire logic i_raw,
  // link to top
  cmpl_chan_if.channel ctl
);
  logic raw_s1_reg;
  logic raw_s2_reg;
  logic raw_s3_reg;
  logic level_reg;
  logic out_bit_reg;
  logic out_bit_next;
  logic rise_reg;
  logic fall_reg;
  logic ext_reg;

  ////////////////////////////////////////////////////////////////////////
  // three-stage synchroniser; level moves only when stages two and three agree
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      raw_s1_reg <= 1'b0;
      raw_s2_reg <= 1'b0;
      raw_s3_reg <= 1'b0;
      level_reg <= 1'b0;
    end
    else
    begin
      raw_s1_reg <= i_raw;
      raw_s2_reg <= raw_s1_reg;
      raw_s3_reg <= raw_s2_reg;
      if (raw_s2_reg == raw_s3_reg)
        level_reg <= raw_s3_reg; // high means noninverting above inverting
    end
  end

  // a disabled comparator reads as low before the polarity stage
  assign out_bit_next = (ctl.enable & level_reg) ^ ctl.invert;

  ////////////////////////////////////////////////////////////////////////
  // internal output latched once per instruction cycle, edges seen there
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      out_bit_reg <= 1'b0;
      rise_reg <= 1'b0;
      fall_reg <= 1'b0;
    end
    else
    begin
      rise_reg <= ctl.instr_tick & out_bit_next & ~out_bit_reg;
      fall_reg <= ctl.instr_tick & ~out_bit_next & out_bit_reg;
      if (ctl.instr_tick)
        out_bit_reg <= out_bit_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // external output: follows freely, or waits for the timer's falling edge
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
      ext_reg <= 1'b0;
    else if (!ctl.sync_sel)
      ext_reg <= out_bit_next;
    else if (ctl.timer_fall)
      ext_reg <= out_bit_reg; // timer counts on rising edges, so no race
  end

  assign ctl.out_bit = out_bit_reg;
  assign ctl.rise = rise_reg;
  assign ctl.fall = fall_reg;
  assign ctl.ext_out = ext_reg;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  polarity_latch_a: assert property (ctl.instr_tick |=>
    out_bit_reg == $past((ctl.enable & level_reg) ^ ctl.invert))
    else $error("output bit does not follow polarity");
  hold_between_ticks_a: assert property (!ctl.instr_tick |=> $stable(out_bit_reg))
    else $error("output bit moved between instruction ticks");
  rise_edge_a: assert property (rise_reg |-> out_bit_reg && !$past(out_bit_reg))
    else $error("rise pulse without positive edge");
  fall_edge_a: assert property (fall_reg |-> !out_bit_reg && $past(out_bit_reg))
    else $error("fall pulse without negative edge");
  sync_hold_a: assert property (ctl.sync_sel && !ctl.timer_fall |=> $stable(ext_reg))
    else $error("synchronised output moved off the timer edge");
  async_path_a: assert property (!ctl.sync_sel |=>
    ext_reg == $past((ctl.enable & level_reg) ^ ctl.invert))
    else $error("free output does not follow result");
  rise_seen_c: cover property (rise_reg);
  fall_seen_c: cover property (fall_reg);
  sync_latch_c: cover property (ctl.sync_sel && ctl.timer_fall ##1 $changed(ext_reg));
endmodule // cmpl_channel

//--- verilog/cmpl_output_logic.sv
// comparator output logic: register file over avalon-mm and channel glue
//
// The implementer's own choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/10ps
`include "cmpl_map.svh"

module cmpl_output_logic
  import cmpl_pkg::*;
#(
  parameter int unsigned NUM_COMP = 2, // comparator instances
  parameter int unsigned INSTR_DIV = `CMPL_INSTR_DIV // core clocks per instruction cycle
)(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // avalon-mm slave
  input wire logic [4:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  // analog side
  input wire logic [NUM_COMP-1:0] i_compare_raw,
  output logic [NUM_COMP-1:0] o_comparator_enable,
  output logic [NUM_COMP-1:0] o_hysteresis_enable,
  output logic [NUM_COMP-1:0] o_speed_power_select,
  output logic [3*NUM_COMP-1:0] o_pos_channel,
  output logic [3*NUM_COMP-1:0] o_neg_channel,
  // sync timer side
  input wire logic i_timer_clock,
  output logic [NUM_COMP-1:0] o_sync_out,
  // interrupt flags
  output logic [NUM_COMP-1:0] o_irq_flag,
  output logic o_irq_request
);
  cmpl_bus_t bus_state_reg;
  logic waitrequest_reg;
  logic [31:0] readdata_reg;
  logic [31:0] rd_value;
  logic wr_en;
  logic [7:0] div_cnt_reg;
  logic instr_tick_reg;
  logic tclk_s1_reg;
  logic tclk_s2_reg;
  logic tclk_s3_reg;
  logic tclk_level_reg;
  logic timer_fall_reg;
  logic [NUM_COMP-1:0] flag_reg;
  logic [NUM_COMP-1:0] flag_next;
  logic [NUM_COMP-1:0] irq_en_reg;
  cmpl_byte_t irq_ctrl_reg;
  logic irq_request_reg;
  logic [NUM_COMP-1:0] out_vec;
  logic [NUM_COMP-1:0] set_vec;
  logic [NUM_COMP-1:0][7:0] ctrl_a_vec;
  logic [NUM_COMP-1:0][7:0] ctrl_b_vec;

  // instance count limited to the two variants; divider must fit its counter
  if (NUM_COMP < 1 || NUM_COMP > 2)
  begin : g_bad_count
    $error("NUM_COMP must be 1 or 2");
  end
  if (INSTR_DIV < 1 || INSTR_DIV > 256)
  begin : g_bad_div
    $error("INSTR_DIV must be 1 to 256");
  end

  // word compare of an address against a register offset
  function automatic logic addr_is(input logic [4:0] addr, input logic [4:0] ofs);
    return addr[4:2] == ofs[4:2];
  endfunction

  // offset of a per-channel register
  function automatic logic [4:0] chan_ofs(input logic [4:0] base, input int k);
    return 5'(base + `CMPL_CHAN_STRIDE * 5'(k));
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // bus handshake: waitrequest drops for one cycle, one cycle after the request
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      bus_state_reg <= CMPL_BUS_IDLE;
      waitrequest_reg <= 1'b1;
    end
    else
    begin
      unique case (bus_state_reg)
        CMPL_BUS_IDLE:
        begin
          if (i_read || i_write)
          begin
            bus_state_reg <= CMPL_BUS_ANSWER;
            waitrequest_reg <= 1'b0;
          end
        end
        CMPL_BUS_ANSWER:
        begin
          bus_state_reg <= CMPL_BUS_IDLE;
          waitrequest_reg <= 1'b1;
        end
      endcase
    end
  end

  // writes land on the edge where the master sees waitrequest low
  assign wr_en = (bus_state_reg == CMPL_BUS_ANSWER) && i_write && i_byteenable[0];

  ////////////////////////////////////////////////////////////////////////
  // read multiplexer; unmapped words read as zero
  always_comb
  begin
    rd_value = 32'h0000_0000;
    for (int k = 0; k < NUM_COMP; k++)
    begin
      if (addr_is(i_address, chan_ofs(`CMPL_OFS_CTRL_A0, k)))
        rd_value[7:0] = ctrl_a_vec[k];
      if (addr_is(i_address, chan_ofs(`CMPL_OFS_CTRL_B0, k)))
        rd_value[7:0] = ctrl_b_vec[k];
    end
    if (addr_is(i_address, `CMPL_OFS_SHARED))
      rd_value[NUM_COMP-1:0] = out_vec;
    if (addr_is(i_address, `CMPL_OFS_IRQ_FLAG))
      rd_value[NUM_COMP-1:0] = flag_reg;
    if (addr_is(i_address, `CMPL_OFS_IRQ_EN))
      rd_value[NUM_COMP-1:0] = irq_en_reg;
    if (addr_is(i_address, `CMPL_OFS_IRQ_CTRL))
      rd_value[7:0] = irq_ctrl_reg;
  end

  // read data captured when the answer starts, so it stands at the taking edge
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
      readdata_reg <= 32'h0000_0000;
    else if (bus_state_reg == CMPL_BUS_IDLE && i_read)
      readdata_reg <= rd_value;
  end

  ////////////////////////////////////////////////////////////////////////
  // instruction-cycle enable from the core clock
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      div_cnt_reg <= 8'h00;
      instr_tick_reg <= 1'b0;
    end
    else
    begin
      instr_tick_reg <= (div_cnt_reg == 8'(INSTR_DIV - 1));
      if (div_cnt_reg == 8'(INSTR_DIV - 1))
        div_cnt_reg <= 8'h00;
      else
        div_cnt_reg <= div_cnt_reg + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // prescaled timer clock sampled as a pin; falling edge becomes a pulse
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      tclk_s1_reg <= 1'b0;
      tclk_s2_reg <= 1'b0;
      tclk_s3_reg <= 1'b0;
      tclk_level_reg <= 1'b0;
      timer_fall_reg <= 1'b0;
    end
    else
    begin
      tclk_s1_reg <= i_timer_clock;
      tclk_s2_reg <= tclk_s1_reg;
      tclk_s3_reg <= tclk_s2_reg;
      timer_fall_reg <= (tclk_s2_reg == tclk_s3_reg) && tclk_level_reg && !tclk_s3_reg;
      if (tclk_s2_reg == tclk_s3_reg)
        tclk_level_reg <= tclk_s3_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // one channel per comparator, each with its own registers and detectors
  for (genvar k = 0; k < NUM_COMP; k++)
  begin : g_chan
    cmpl_byte_t ctrl_a_reg;
    cmpl_byte_t ctrl_b_reg;
    cmpl_chan_if link ();

    // control registers; output bit is read-only and stored as zero
    always_ff @(posedge i_clock)
    begin
      if (!i_rst_n)
      begin
        ctrl_a_reg <= `CMPL_A_RESET;
        ctrl_b_reg <= `CMPL_B_RESET;
      end
      else if (wr_en)
      begin
        if (addr_is(i_address, chan_ofs(`CMPL_OFS_CTRL_A0, k)))
          ctrl_a_reg <= i_writedata[7:0] & `CMPL_A_WMASK; // speed bit kept as written
        if (addr_is(i_address, chan_ofs(`CMPL_OFS_CTRL_B0, k)))
          ctrl_b_reg <= i_writedata[7:0];
      end
    end

    assign link.enable = ctrl_a_reg[`CMPL_A_ENABLE];
    assign link.invert = ctrl_a_reg[`CMPL_A_INVERT];
    assign link.sync_sel = ctrl_a_reg[`CMPL_A_SYNC];
    assign link.instr_tick = instr_tick_reg;
    assign link.timer_fall = timer_fall_reg;

    cmpl_channel u_channel (
      .i_clock (i_clock),
      .i_rst_n (i_rst_n),
      .i_raw (i_compare_raw[k]),
      .ctl (link.channel)
    );

    // readback shows the live output bit in its documented slot
    always_comb
    begin
      ctrl_a_vec[k] = ctrl_a_reg;
      ctrl_a_vec[k][`CMPL_A_OUTPUT] = link.out_bit;
    end
    assign ctrl_b_vec[k] = ctrl_b_reg;
    assign out_vec[k] = link.out_bit;
    assign set_vec[k] = (link.rise & ctrl_b_reg[`CMPL_B_RISE])
      | (link.fall & ctrl_b_reg[`CMPL_B_FALL]);
    assign o_sync_out[k] = link.ext_out;
    assign o_comparator_enable[k] = ctrl_a_reg[`CMPL_A_ENABLE];
    assign o_hysteresis_enable[k] = ctrl_a_reg[`CMPL_A_HYST];
    assign o_speed_power_select[k] = ctrl_a_reg[`CMPL_A_SPEED];
    assign o_pos_channel[3*k +: 3] = ctrl_b_reg[`CMPL_B_PCH_LSB +: 3];
    assign o_neg_channel[3*k +: 3] = ctrl_b_reg[`CMPL_B_NCH_LSB +: 3];
  end

  ////////////////////////////////////////////////////////////////////////
  // flags: software write stores, hardware set is or-ed on top so it wins
  always_comb
  begin
    flag_next = flag_reg;
    if (wr_en && addr_is(i_address, `CMPL_OFS_IRQ_FLAG))
      flag_next = i_writedata[NUM_COMP-1:0];
    flag_next = flag_next | set_vec;
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
      flag_reg <= '0;
    else
      flag_reg <= flag_next;
  end

  // enables for the request line
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      irq_en_reg <= '0;
      irq_ctrl_reg <= 8'h00;
    end
    else if (wr_en)
    begin
      if (addr_is(i_address, `CMPL_OFS_IRQ_EN))
        irq_en_reg <= i_writedata[NUM_COMP-1:0];
      if (addr_is(i_address, `CMPL_OFS_IRQ_CTRL))
        irq_ctrl_reg <= i_writedata[7:0] & 8'hC0;
    end
  end

  // request follows flags one cycle later, gated by all three enables
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
      irq_request_reg <= 1'b0;
    else
      irq_request_reg <= (|(flag_reg & irq_en_reg)) & irq_ctrl_reg[`CMPL_C_GLOBAL]
        & irq_ctrl_reg[`CMPL_C_PERIPH];
  end

  assign o_readdata = readdata_reg;
  assign o_waitrequest = waitrequest_reg;
  assign o_irq_flag = flag_reg;
  assign o_irq_request = irq_request_reg;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  flag_set_a: assert property ((set_vec != '0) |=>
    (flag_reg & $past(set_vec)) == $past(set_vec))
    else $error("enabled edge did not set its flag");
  set_wins_a: assert property ((set_vec != '0) && wr_en
    && addr_is(i_address, `CMPL_OFS_IRQ_FLAG) |=> (flag_reg & $past(set_vec)) == $past(set_vec))
    else $error("clear beat a simultaneous set");
  flag_sticky_a: assert property (!(wr_en && addr_is(i_address, `CMPL_OFS_IRQ_FLAG)) |=>
    (flag_reg & $past(flag_reg)) == $past(flag_reg))
    else $error("flag cleared without software");
  bus_answer_a: assert property (bus_state_reg == CMPL_BUS_IDLE && (i_read || i_write) |=>
    !o_waitrequest ##1 o_waitrequest)
    else $error("answer not one cycle after request");
  mirror_read_a: assert property (bus_state_reg == CMPL_BUS_IDLE && i_read
    && addr_is(i_address, `CMPL_OFS_SHARED) |=> o_readdata == 32'($past(out_vec)))
    else $error("shared register does not mirror outputs");
  flag_write_c: cover property (wr_en && addr_is(i_address, `CMPL_OFS_IRQ_FLAG)
    && set_vec != '0);
  irq_req_c: cover property ($rose(o_irq_request));
endmodule // cmpl_output_logic

//--- bench/testbench.sv
// self-checking testbench for the comparator output logic over avalon-mm
`timescale 1ns/10ps
`include "cmpl_map.svh"
module testbench
  import cmpl_pkg::*;
;
  localparam int unsigned NC = 2;
  ////////////////////////////////////////////////////////////////////////////
  // clock, reset, design inputs and outputs
  logic i_clock;
  logic i_rst_n;
  logic [4:0] i_address;
  logic i_read;
  logic i_write;
  logic [31:0] i_writedata;
  logic [3:0] i_byteenable;
  logic [31:0] o_readdata;
  logic o_waitrequest;
  logic [NC-1:0] i_compare_raw;
  logic [NC-1:0] o_comparator_enable;
  logic [NC-1:0] o_hysteresis_enable;
  logic [NC-1:0] o_speed_power_select;
  logic [3*NC-1:0] o_pos_channel;
  logic [3*NC-1:0] o_neg_channel;
  logic i_timer_clock;
  logic [NC-1:0] o_sync_out;
  logic [NC-1:0] o_irq_flag;
  logic o_irq_request;
  int n_fail;
  int comparisons;
  cmpl_byte_t rd;

  // short instruction tick keeps the settle waits small
  cmpl_output_logic #(.NUM_COMP(NC), .INSTR_DIV(2)) DUT (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_address(i_address), .i_read(i_read),
    .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(i_byteenable),
    .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
    .i_compare_raw(i_compare_raw), .o_comparator_enable(o_comparator_enable),
    .o_hysteresis_enable(o_hysteresis_enable),
    .o_speed_power_select(o_speed_power_select), .o_pos_channel(o_pos_channel),
    .o_neg_channel(o_neg_channel), .i_timer_clock(i_timer_clock),
    .o_sync_out(o_sync_out), .o_irq_flag(o_irq_flag), .o_irq_request(o_irq_request)
  );

  // 100 MHz core clock
  initial
  begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  ////////////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge i_clock);
  endtask

  // one avalon access; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] adr, input logic [7:0] d,
      input logic [3:0] be);
    int n;
    n = 0;
    @(posedge i_clock);
    i_address <= adr;
    i_writedata <= {24'h000000, d};
    i_byteenable <= be;
    i_write <= wr;
    i_read <= ~wr;
    do
    begin
      @(posedge i_clock);
      n++;
    end while (o_waitrequest !== 1'b0 && n < 100);
    // a slave that never answers ends the run at the verdict
    if (n >= 100)
    begin
      check("bus answer", 32'h0, 32'h1);
      finish_test();
    end
    rd = o_readdata[7:0];
    if (!wr)
      check("upper read bits", 32'h0, {8'h00, o_readdata[31:8]});
    i_write <= 1'b0;
    i_read <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] adr, input logic [7:0] d);
    bus(1'b1, adr, d, 4'hF);
  endtask

  task automatic rd_chk(input string name, input logic [4:0] adr, input logic [7:0] exp);
    bus(1'b0, adr, 8'h00, 4'hF);
    check(name, {24'h0, exp}, {24'h0, rd});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // watchdog sized well above the expected run of about 400 cycles
  initial
  begin
    wait_clk(20000);
    n_fail++;
    finish_test();
  end

  // main sequence
  initial
  begin
    i_rst_n = 1'b0;
    i_address = 5'h00;
    i_read = 1'b0;
    i_write = 1'b0;
    i_writedata = 32'h0;
    i_byteenable = 4'h0;
    i_compare_raw = '0;
    i_timer_clock = 1'b1;
    n_fail = 0;
    comparisons = 0;
    wait_clk(20);
    i_rst_n <= 1'b1;
    // reset values
    rd_chk("ctrl a0 reset", `CMPL_OFS_CTRL_A0, `CMPL_A_RESET);
    rd_chk("ctrl b0 reset", `CMPL_OFS_CTRL_B0, `CMPL_B_RESET);
    rd_chk("shared reset", `CMPL_OFS_SHARED, 8'h00);
    check("speed select", 32'h3, {30'h0, o_speed_power_select});
    // write without low byte enable is ignored
    bus(1'b1, `CMPL_OFS_CTRL_A0, 8'hFF, 4'hE);
    rd_chk("ctrl a0 masked", `CMPL_OFS_CTRL_A0, `CMPL_A_RESET);
    // all writable bits; invert with raw low gives output 1
    wr(`CMPL_OFS_CTRL_A0, 8'hFF);
    wait_clk(12);
    rd_chk("ctrl a0 all", `CMPL_OFS_CTRL_A0, 8'hD7);
    check("enable out", 32'h1, {31'h0, o_comparator_enable[0]});
    check("hysteresis out", 32'h1, {31'h0, o_hysteresis_enable[0]});
    // polarity table, asynchronous output
    for (int k = 0; k < 4; k++)
    begin
      wr(`CMPL_OFS_CTRL_A0, 8'h84 | (k[1] << 4));
      i_compare_raw[0] <= k[0];
      wait_clk(12);
      rd_chk("ctrl a0 output", `CMPL_OFS_CTRL_A0,
        8'h84 | (k[1] << 4) | ((k[0] ^ k[1]) << 6));
      rd_chk("shared bit0", `CMPL_OFS_SHARED, {7'h0, k[0] ^ k[1]});
      check("async out", {31'h0, k[0] ^ k[1]}, {31'h0, o_sync_out[0]});
    end
    // second comparator mirrors at bit 1
    wr(`CMPL_OFS_CTRL_A1, 8'h84);
    i_compare_raw[1] <= 1'b1;
    wait_clk(12);
    rd_chk("shared bit1", `CMPL_OFS_SHARED, 8'h02);
    wr(`CMPL_OFS_CTRL_A1, 8'h04);
    wait_clk(12);
    check("enable1 off", 32'h0, {31'h0, o_comparator_enable[1]});
    rd_chk("shared disabled", `CMPL_OFS_SHARED, 8'h00);
    // input channel selects reach their outputs; read first so the register has settled
    wr(`CMPL_OFS_CTRL_B0, 8'h2B);
    rd_chk("ctrl b0 write", `CMPL_OFS_CTRL_B0, 8'h2B);
    check("pos channel", 32'h5, {26'h0, o_pos_channel});
    check("neg channel", 32'h3, {26'h0, o_neg_channel});
    // rising edge interrupt
    wr(`CMPL_OFS_CTRL_A0, 8'h84);
    i_compare_raw[0] <= 1'b0;
    wr(`CMPL_OFS_CTRL_B0, 8'h80);
    wait_clk(12);
    wr(`CMPL_OFS_IRQ_FLAG, 8'h00);
    i_compare_raw[0] <= 1'b1;
    wait_clk(12);
    rd_chk("flag rise", `CMPL_OFS_IRQ_FLAG, 8'h01);
    wr(`CMPL_OFS_IRQ_EN, 8'h01);
    wr(`CMPL_OFS_IRQ_CTRL, 8'hC0);
    wait_clk(4);
    check("irq request", 32'h1, {31'h0, o_irq_request});
    i_compare_raw[0] <= 1'b0;
    wait_clk(30);
    rd_chk("flag held", `CMPL_OFS_IRQ_FLAG, 8'h01);
    wr(`CMPL_OFS_IRQ_FLAG, 8'h00);
    rd_chk("flag cleared", `CMPL_OFS_IRQ_FLAG, 8'h00);
    // falling edge only
    wr(`CMPL_OFS_CTRL_B0, 8'h40);
    i_compare_raw[0] <= 1'b1;
    wait_clk(12);
    rd_chk("rise ignored", `CMPL_OFS_IRQ_FLAG, 8'h00);
    i_compare_raw[0] <= 1'b0;
    wait_clk(12);
    rd_chk("flag fall", `CMPL_OFS_IRQ_FLAG, 8'h01);
    check("flag port", 32'h1, {31'h0, o_irq_flag[0]});
    wr(`CMPL_OFS_IRQ_CTRL, 8'h40);
    wait_clk(4);
    check("irq masked", 32'h0, {31'h0, o_irq_request});
    // polarity flip while disabled still makes an edge
    wr(`CMPL_OFS_CTRL_B0, 8'h80);
    wr(`CMPL_OFS_CTRL_A0, 8'h04);
    wait_clk(12);
    wr(`CMPL_OFS_IRQ_FLAG, 8'h00);
    // one spare cycle puts the edge pulse on the very edge where the clear below lands
    wait_clk(1);
    wr(`CMPL_OFS_CTRL_A0, 8'h14);
    wr(`CMPL_OFS_IRQ_FLAG, 8'h00);
    wait_clk(12);
    rd_chk("flag invert", `CMPL_OFS_IRQ_FLAG, 8'h01);
    // timer synchronised output on comparator 1
    wr(`CMPL_OFS_CTRL_A1, 8'h85);
    wait_clk(12);
    check("sync waits", 32'h0, {31'h0, o_sync_out[1]});
    i_timer_clock <= 1'b0;
    wait_clk(12);
    check("sync on fall", 32'h1, {31'h0, o_sync_out[1]});
    i_timer_clock <= 1'b1;
    i_compare_raw[1] <= 1'b0;
    wait_clk(12);
    check("no latch on rise", 32'h1, {31'h0, o_sync_out[1]});
    i_timer_clock <= 1'b0;
    wait_clk(12);
    check("sync second fall", 32'h0, {31'h0, o_sync_out[1]});
    finish_test();
  end
endmodule // testbench
